// ---- cit_step_counter.sv ----
// Timing package and the execution-cycle step counter
`timescale 1ns/1ps

// ==========================================================================
// Package
// ==========================================================================
package cit_pkg;

  // Field widths
  localparam int unsigned CIT_LEN_W = 2;
  localparam int unsigned CIT_CYC_W = 4;
  localparam int unsigned CIT_OPND_W = 16;

  // Program byte counts
  localparam logic [1:0] CIT_LEN_ONE = 2'h1;
  localparam logic [1:0] CIT_LEN_TWO = 2'h2;
  localparam logic [1:0] CIT_LEN_THREE = 2'h3;

  // Execution clock counts
  localparam logic [3:0] CIT_CYC_ONE = 4'h1;
  localparam logic [3:0] CIT_CYC_TWO = 4'h2;
  localparam logic [3:0] CIT_CYC_THREE = 4'h3;
  localparam logic [3:0] CIT_CYC_FOUR = 4'h4;
  localparam logic [3:0] CIT_CYC_EIGHT = 4'h8;
  localparam logic [3:0] CIT_CYC_MAX = CIT_CYC_EIGHT;

  // Reset values
  localparam logic [15:0] CIT_OPND_RST = 16'h0000;
  localparam logic [3:0] CIT_IDX_RST = 4'h0;

  // Instruction timing classes
  typedef enum logic [4:0] {
    CIT_ARITH_REG,
    CIT_ARITH_DIRECT,
    CIT_ARITH_INDIRECT,
    CIT_ARITH_IMM,
    CIT_LOGIC_DIR_ACC,
    CIT_LOGIC_DIR_IMM,
    CIT_ACC_ONLY,
    CIT_MOVE_DIR_DIR,
    CIT_LOAD_DATA_PTR,
    CIT_CODE_READ,
    CIT_EXT_INDEX,
    CIT_EXT_DATA_PTR,
    CIT_STACK_OP,
    CIT_NIBBLE_XCH,
    CIT_XCH_INDIRECT,
    CIT_XCH_REG,
    CIT_STORE_INDIRECT,
    CIT_IMM_TO_INDIRECT,
    CIT_IMM_TO_DIRECT,
    CIT_MULTIPLY,
    CIT_DIVIDE,
    CIT_CARRY_OP,
    CIT_BIT_OP,
    CIT_INCDEC_SHORT,
    CIT_INCDEC_DIRECT,
    CIT_INCDEC_INDIRECT
  } cit_class_t;

  // Length and duration of one instruction
  typedef struct packed {
    logic [1:0] len;
    logic [3:0] cycles;
  } cit_shape_t;

  // Record of the instruction in flight
  typedef struct packed {
    cit_class_t cls;
    logic [1:0] len;
    logic [3:0] cycles;
    logic [15:0] operand;
  } cit_info_t;

  // Timing table lookup
  function automatic cit_shape_t cit_shape_of(input cit_class_t c);
    cit_shape_t s;
    s = '{len: CIT_LEN_ONE, cycles: CIT_CYC_ONE};
    case (c)
      CIT_ARITH_DIRECT, CIT_ARITH_IMM, CIT_LOGIC_DIR_ACC, CIT_STACK_OP,
      CIT_IMM_TO_INDIRECT, CIT_BIT_OP, CIT_INCDEC_DIRECT: begin
        s = '{len: CIT_LEN_TWO, cycles: CIT_CYC_TWO};
      end
      CIT_ARITH_INDIRECT, CIT_NIBBLE_XCH, CIT_XCH_INDIRECT,
      CIT_STORE_INDIRECT, CIT_INCDEC_INDIRECT: begin
        s = '{len: CIT_LEN_ONE, cycles: CIT_CYC_TWO};
      end
      CIT_LOGIC_DIR_IMM, CIT_MOVE_DIR_DIR, CIT_LOAD_DATA_PTR,
      CIT_IMM_TO_DIRECT: begin
        s = '{len: CIT_LEN_THREE, cycles: CIT_CYC_THREE};
      end
      CIT_CODE_READ, CIT_EXT_INDEX, CIT_EXT_DATA_PTR: begin
        s = '{len: CIT_LEN_ONE, cycles: CIT_CYC_THREE};
      end
      CIT_MULTIPLY: begin
        s = '{len: CIT_LEN_ONE, cycles: CIT_CYC_FOUR};
      end
      CIT_DIVIDE: begin
        s = '{len: CIT_LEN_ONE, cycles: CIT_CYC_EIGHT};
      end
      default: begin
        s = '{len: CIT_LEN_ONE, cycles: CIT_CYC_ONE};
      end
    endcase
    return s;
  endfunction : cit_shape_of

endpackage : cit_pkg

// ==========================================================================
// Step counter: walks index 0..span-1 while busy
// ==========================================================================
module cit_step_counter #(
  parameter int unsigned W = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Control
  input wire logic start,
  input wire logic [W-1:0] span,
  // Status
  output logic busy,
  output logic [W-1:0] index,
  output logic last
);

  logic busy_q, busy_d;
  logic [W-1:0] index_q, index_d;
  logic [W-1:0] span_q, span_d;

  // Final step of the current span
  assign last = busy_q && (index_q == (span_q - W'(1)));
  assign busy = busy_q;
  assign index = index_q;

  // Next state: a start wins over the end of the old span
  always_comb begin
    busy_d = busy_q;
    index_d = index_q;
    span_d = span_q;
    if (start) begin
      busy_d = 1'b1;
      index_d = '0;
      span_d = span;
    end else if (last) begin
      busy_d = 1'b0;
    end else if (busy_q) begin
      index_d = index_q + W'(1);
    end
  end

  // State registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busy_q <= 1'b0;
      index_q <= '0;
      span_q <= '0;
    end else begin
      busy_q <= busy_d;
      index_q <= index_d;
      span_q <= span_d;
    end
  end

endmodule : cit_step_counter

// ---- cit_sequencer.sv ----
// Instruction sequencer: program byte fetch and execution-cycle timing
//
// Behaviour
// - Add, carry add, borrow subtract from bank register: 1 byte, 1 cycle
// - Arithmetic with direct byte source: 2 bytes, 2 cycles
// - Arithmetic with indirect RAM source: 1 byte, 2 cycles
// - Arithmetic with immediate source: 2 bytes, 2 cycles
// - Logic accumulator into direct byte: 2 bytes, 2 cycles
// - Logic immediate into direct byte: 3 bytes, 3 cycles
// - Accumulator-only clear, complement, swap, rotates: 1 byte, 1 cycle
// - Direct to direct move: 3 bytes, 3 cycles
// - Data pointer load carries 16-bit constant: 3 bytes, 3 cycles
// - Code memory reads relative to counter or pointer: 1 byte, 3 cycles
// - External data move with 8-bit index address: 1 byte, 3 cycles
// - External data move with 16-bit pointer address: 1 byte, 3 cycles
// - Stack push and pop of direct byte: 2 bytes, 2 cycles
// - Low nibble exchange with indirect RAM: 1 byte, 2 cycles
// - Byte exchange indirect: 1 byte, 2 cycles; bank register: 1 cycle
// - Accumulator store to indirect RAM: 1 byte, 2 cycles
// - Immediate to indirect RAM: 2 bytes, 2 cycles
// - Immediate to direct byte: 3 bytes, 3 cycles
`timescale 1ns/1ps

module cit_sequencer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Instruction issue
  input wire logic issue_valid,
  input wire cit_pkg::cit_class_t issue_class,
  output logic issue_ready,
  // Operand byte fetch from code memory
  output logic code_req,
  input wire logic [7:0] code_data,
  // Retirement
  output logic retire_valid,
  output cit_pkg::cit_info_t retire_info,
  output logic busy
);

  // ========================================================================
  // Issue and step counting
  // ========================================================================
  logic issue_fire;
  cit_pkg::cit_shape_t shape_in;
  logic [3:0] step_idx;
  logic step_last;
  logic step_busy;
  logic [1:0] len_m1;

  // Table lookup sets length and duration
  assign shape_in = cit_pkg::cit_shape_of(issue_class);
  assign issue_fire = issue_valid && issue_ready;

  // Cycle counter owns the duration of each instruction
  cit_step_counter #(
    .W(cit_pkg::CIT_CYC_W)
  ) u_steps (
    .ref_clk(ref_clk),
    .srst(srst),
    .start(issue_fire),
    .span(shape_in.cycles),
    .busy(step_busy),
    .index(step_idx),
    .last(step_last)
  );

  // ========================================================================
  // Instruction record and operand assembly
  // ========================================================================
  cit_pkg::cit_info_t info_q, info_d;

  // Operand bytes shift in; of two fetched bytes the first ends up high, a single byte sits low
  always_comb begin
    info_d = info_q;
    if (issue_fire) begin
      info_d.cls = issue_class;
      info_d.len = shape_in.len;
      info_d.cycles = shape_in.cycles;
      info_d.operand = cit_pkg::CIT_OPND_RST;
    end else if (code_req) begin
      info_d.operand = {info_q.operand[7:0], code_data};
    end
  end

  // Record register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      info_q <= '{cls: cit_pkg::CIT_ARITH_REG,
                  len: cit_pkg::CIT_LEN_ONE,
                  cycles: cit_pkg::CIT_CYC_ONE,
                  operand: cit_pkg::CIT_OPND_RST};
    end else begin
      info_q <= info_d;
    end
  end

  // ========================================================================
  // Handshake outputs
  // ========================================================================
  // One operand fetch per cycle in the leading cycles
  assign len_m1 = info_q.len - 2'h1;
  assign code_req = step_busy && (step_idx < {2'h0, len_m1});
  assign retire_valid = step_last;
  // Back to back issue in the final cycle
  assign issue_ready = !step_busy || step_last;
  assign busy = step_busy;
  assign retire_info = info_q;

  // ========================================================================
  // Checking helpers
  // ========================================================================
  logic [3:0] elapsed_q, elapsed_d;
  logic [3:0] fetched_q, fetched_d;
  cit_pkg::cit_class_t seen_q, seen_d;

  // Independent measurement of span and fetches
  always_comb begin
    elapsed_d = elapsed_q;
    fetched_d = fetched_q;
    seen_d = seen_q;
    if (issue_fire) begin
      elapsed_d = 4'h1;
      fetched_d = 4'h0;
      seen_d = issue_class;
    end else begin
      elapsed_d = elapsed_q + 4'h1;
      fetched_d = fetched_q + {3'h0, code_req};
    end
  end

  // Helper registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      elapsed_q <= 4'h0;
      fetched_q <= 4'h0;
      seen_q <= cit_pkg::CIT_ARITH_REG;
    end else begin
      elapsed_q <= elapsed_d;
      fetched_q <= fetched_d;
      seen_q <= seen_d;
    end
  end

  // ========================================================================
  // Assertions
  // ========================================================================
  // Retire of class c after n cycles with l-1 operand fetches
  property p_shape(cit_pkg::cit_class_t c, int l, int n);
    @(posedge ref_clk) disable iff (srst)
      (retire_valid && seen_q == c) |->
        (elapsed_q == n && fetched_q == l - 1 && retire_info.len == l);
  endproperty

  a_arith_reg_time: assert property (
    p_shape(cit_pkg::CIT_ARITH_REG, 1, 1))
    else $error("bank register arithmetic timing wrong");
  a_arith_direct_time: assert property (
    p_shape(cit_pkg::CIT_ARITH_DIRECT, 2, 2))
    else $error("direct arithmetic timing wrong");
  a_arith_indirect_time: assert property (
    p_shape(cit_pkg::CIT_ARITH_INDIRECT, 1, 2))
    else $error("indirect arithmetic timing wrong");
  a_arith_imm_time: assert property (
    p_shape(cit_pkg::CIT_ARITH_IMM, 2, 2))
    else $error("immediate arithmetic timing wrong");
  a_logic_acc_time: assert property (
    p_shape(cit_pkg::CIT_LOGIC_DIR_ACC, 2, 2))
    else $error("logic into direct byte timing wrong");
  a_logic_imm_time: assert property (
    p_shape(cit_pkg::CIT_LOGIC_DIR_IMM, 3, 3))
    else $error("logic immediate into direct timing wrong");
  a_acc_only_time: assert property (
    p_shape(cit_pkg::CIT_ACC_ONLY, 1, 1))
    else $error("accumulator-only timing wrong");
  a_move_dd_time: assert property (
    p_shape(cit_pkg::CIT_MOVE_DIR_DIR, 3, 3))
    else $error("direct to direct move timing wrong");
  a_ptr_load_time: assert property (
    p_shape(cit_pkg::CIT_LOAD_DATA_PTR, 3, 3))
    else $error("pointer load timing wrong");
  a_code_read_time: assert property (
    p_shape(cit_pkg::CIT_CODE_READ, 1, 3))
    else $error("code memory read timing wrong");
  a_ext_index_time: assert property (
    p_shape(cit_pkg::CIT_EXT_INDEX, 1, 3))
    else $error("external index move timing wrong");
  a_ext_ptr_time: assert property (
    p_shape(cit_pkg::CIT_EXT_DATA_PTR, 1, 3))
    else $error("external pointer move timing wrong");
  a_stack_op_time: assert property (
    p_shape(cit_pkg::CIT_STACK_OP, 2, 2))
    else $error("stack operation timing wrong");
  a_nibble_xch_time: assert property (
    p_shape(cit_pkg::CIT_NIBBLE_XCH, 1, 2))
    else $error("nibble exchange timing wrong");
  a_xch_ind_time: assert property (
    p_shape(cit_pkg::CIT_XCH_INDIRECT, 1, 2))
    else $error("indirect exchange timing wrong");
  a_xch_reg_time: assert property (
    p_shape(cit_pkg::CIT_XCH_REG, 1, 1))
    else $error("register exchange timing wrong");
  a_store_ind_time: assert property (
    p_shape(cit_pkg::CIT_STORE_INDIRECT, 1, 2))
    else $error("indirect store timing wrong");
  a_imm_ind_time: assert property (
    p_shape(cit_pkg::CIT_IMM_TO_INDIRECT, 2, 2))
    else $error("immediate to indirect timing wrong");
  a_imm_dir_time: assert property (
    p_shape(cit_pkg::CIT_IMM_TO_DIRECT, 3, 3))
    else $error("immediate to direct timing wrong");
  a_multiply_time: assert property (
    p_shape(cit_pkg::CIT_MULTIPLY, 1, 4))
    else $error("multiply timing wrong");
  a_carry_op_time: assert property (
    p_shape(cit_pkg::CIT_CARRY_OP, 1, 1))
    else $error("carry operation timing wrong");
  a_bit_op_time: assert property (
    p_shape(cit_pkg::CIT_BIT_OP, 2, 2))
    else $error("addressed bit operation timing wrong");
  a_incdec_short_time: assert property (
    p_shape(cit_pkg::CIT_INCDEC_SHORT, 1, 1))
    else $error("short increment timing wrong");
  a_incdec_dir_time: assert property (
    p_shape(cit_pkg::CIT_INCDEC_DIRECT, 2, 2))
    else $error("direct increment timing wrong");
  a_incdec_ind_time: assert property (
    p_shape(cit_pkg::CIT_INCDEC_INDIRECT, 1, 2))
    else $error("indirect increment timing wrong");
  a_divide_time: assert property (
    p_shape(cit_pkg::CIT_DIVIDE, 1, 8))
    else $error("divide timing wrong");

  // Divide holds for seven cycles then retires on the eighth
  sequence s_div_accept;
    issue_fire && issue_class == cit_pkg::CIT_DIVIDE;
  endsequence
  sequence s_div_run;
    (busy && !retire_valid) [*7] ##1 retire_valid;
  endsequence
  a_divide_span: assert property (
    @(posedge ref_clk) disable iff (srst) s_div_accept |=> s_div_run)
    else $error("divide does not take eight cycles");

  // Pointer load assembles the two fetched bytes, first byte high
  a_ptr_word: assert property (
    @(posedge ref_clk) disable iff (srst)
      (retire_valid && seen_q == cit_pkg::CIT_LOAD_DATA_PTR) |->
        retire_info.operand == {$past(code_data, 2), $past(code_data)})
    else $error("pointer constant assembled wrongly");

  // No instruction outlasts the longest one
  a_span_bound: assert property (
    @(posedge ref_clk) disable iff (srst)
      busy |-> elapsed_q <= cit_pkg::CIT_CYC_MAX)
    else $error("instruction exceeds eight cycles");

  // Issue is held off until the final cycle of a running instruction
  a_issue_block: assert property (
    @(posedge ref_clk) disable iff (srst)
      (busy && !retire_valid) |-> !issue_ready)
    else $error("issue accepted mid instruction");

  // One-cycle classes retire at once without fetching
  sequence s_short_accept;
    issue_fire && issue_class inside {cit_pkg::CIT_ARITH_REG,
      cit_pkg::CIT_ACC_ONLY, cit_pkg::CIT_XCH_REG, cit_pkg::CIT_CARRY_OP,
      cit_pkg::CIT_INCDEC_SHORT};
  endsequence
  a_short_retire: assert property (
    @(posedge ref_clk) disable iff (srst)
      s_short_accept |=> (retire_valid && !code_req))
    else $error("one-cycle class did not retire at once");

  // Three-byte classes fetch in cycles one and two, retire in three
  sequence s_long_accept;
    issue_fire && issue_class inside {cit_pkg::CIT_LOGIC_DIR_IMM,
      cit_pkg::CIT_MOVE_DIR_DIR, cit_pkg::CIT_LOAD_DATA_PTR,
      cit_pkg::CIT_IMM_TO_DIRECT};
  endsequence
  sequence s_long_run;
    (code_req && !retire_valid) [*2] ##1 (retire_valid && !code_req);
  endsequence
  a_long_fetch: assert property (
    @(posedge ref_clk) disable iff (srst) s_long_accept |=> s_long_run)
    else $error("three-byte fetch walk wrong");

  // Three-cycle one-byte classes idle two cycles then retire
  sequence s_slow_accept;
    issue_fire && issue_class inside {cit_pkg::CIT_CODE_READ,
      cit_pkg::CIT_EXT_INDEX, cit_pkg::CIT_EXT_DATA_PTR};
  endsequence
  sequence s_slow_run;
    (!code_req && !retire_valid) [*2] ##1 retire_valid;
  endsequence
  a_slow_retire: assert property (
    @(posedge ref_clk) disable iff (srst) s_slow_accept |=> s_slow_run)
    else $error("three-cycle one-byte walk wrong");

  // Multiply holds for three cycles then retires on the fourth
  sequence s_mul_accept;
    issue_fire && issue_class == cit_pkg::CIT_MULTIPLY;
  endsequence
  sequence s_mul_run;
    (busy && !retire_valid) [*3] ##1 retire_valid;
  endsequence
  a_multiply_span: assert property (
    @(posedge ref_clk) disable iff (srst) s_mul_accept |=> s_mul_run)
    else $error("multiply does not take four cycles");

  // A fresh instruction starts with an empty operand
  a_operand_clear: assert property (
    @(posedge ref_clk) disable iff (srst)
      issue_fire |=> (busy && retire_info.operand == cit_pkg::CIT_OPND_RST))
    else $error("operand not cleared on issue");

endmodule : cit_sequencer

// ---- tb_cpu_instruction_timing.sv ----
// Self-checking testbench for the instruction sequencer timing
`timescale 1ns/1ps

module tb_cpu_instruction_timing;
  // ========================================================================
  // Signals
  // ========================================================================
  logic ref_clk;
  logic srst;
  logic issue_valid;
  cit_pkg::cit_class_t issue_class;
  logic issue_ready;
  logic code_req;
  logic [7:0] code_data;
  logic retire_valid;
  cit_pkg::cit_info_t retire_info;
  logic busy;
  int bad_count = 0;
  int total_checks = 0;
  int cyc_cnt = 0;

  // Device under test
  cit_sequencer dut_u (
    .ref_clk(ref_clk),
    .srst(srst),
    .issue_valid(issue_valid),
    .issue_class(issue_class),
    .issue_ready(issue_ready),
    .code_req(code_req),
    .code_data(code_data),
    .retire_valid(retire_valid),
    .retire_info(retire_info),
    .busy(busy)
  );

  // 50 MHz clock
  initial begin
    ref_clk = 1'h0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ========================================================================
  // Helpers
  // ========================================================================
  // Expected program bytes and clocks, packed as {len, cycles}
  function automatic logic [5:0] exp_shape(input cit_pkg::cit_class_t c);
    case (c)
      cit_pkg::CIT_ARITH_REG, cit_pkg::CIT_ACC_ONLY, cit_pkg::CIT_XCH_REG,
      cit_pkg::CIT_CARRY_OP, cit_pkg::CIT_INCDEC_SHORT:
        return {2'h1, 4'h1};
      cit_pkg::CIT_ARITH_DIRECT, cit_pkg::CIT_ARITH_IMM,
      cit_pkg::CIT_LOGIC_DIR_ACC, cit_pkg::CIT_STACK_OP,
      cit_pkg::CIT_IMM_TO_INDIRECT, cit_pkg::CIT_BIT_OP,
      cit_pkg::CIT_INCDEC_DIRECT:
        return {2'h2, 4'h2};
      cit_pkg::CIT_ARITH_INDIRECT, cit_pkg::CIT_NIBBLE_XCH,
      cit_pkg::CIT_XCH_INDIRECT, cit_pkg::CIT_STORE_INDIRECT,
      cit_pkg::CIT_INCDEC_INDIRECT:
        return {2'h1, 4'h2};
      cit_pkg::CIT_LOGIC_DIR_IMM, cit_pkg::CIT_MOVE_DIR_DIR,
      cit_pkg::CIT_LOAD_DATA_PTR, cit_pkg::CIT_IMM_TO_DIRECT:
        return {2'h3, 4'h3};
      cit_pkg::CIT_CODE_READ, cit_pkg::CIT_EXT_INDEX,
      cit_pkg::CIT_EXT_DATA_PTR:
        return {2'h1, 4'h3};
      cit_pkg::CIT_MULTIPLY:
        return {2'h1, 4'h4};
      default:
        return {2'h1, 4'h8};
    endcase
  endfunction : exp_shape

  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  // Idle state after reset
  task automatic chk_reset();
    chk("issue_ready", issue_ready, 1'h1);
    chk("busy", busy, 1'h0);
    chk("code_req", code_req, 1'h0);
    chk("retire_valid", retire_valid, 1'h0);
    chk("retire_info", retire_info,
        {cit_pkg::CIT_ARITH_REG, 2'h1, 4'h1, 16'h0000});
  endtask : chk_reset

  // One instruction; offer is up on entry. Mode 0 drops the offer,
  // 1 offers the next one in the retire cycle, 2 offers it early
  task automatic run_one(input cit_pkg::cit_class_t c, input int mode,
                         input cit_pkg::cit_class_t nxt);
    logic [5:0] sh;
    logic [15:0] op;
    logic last;
    int w;
    sh = exp_shape(c);
    op = 16'h0000;
    w = 0;
    while (issue_ready !== 1'h1 && w < 20) begin
      @(negedge ref_clk);
      #1;
      w++;
    end
    chk("ready at offer", issue_ready, 1'h1);
    for (int n = 1; n <= int'(sh[3:0]); n++) begin
      @(negedge ref_clk);
      last = (n == int'(sh[3:0]));
      issue_valid = (mode == 2) || (mode == 1 && last);
      issue_class = ((mode == 2) || (mode == 1 && last)) ? nxt : c;
      code_data = 8'($urandom);
      #1;
      if (n < int'(sh[5:4])) begin
        op = {op[7:0], code_data};
      end
      chk("busy", busy, 1'h1);
      chk("issue_ready", issue_ready, last);
      chk("retire_valid", retire_valid, last);
      chk("code_req", code_req, n < int'(sh[5:4]));
    end
    chk("retire cls", retire_info.cls, c);
    chk("retire len", retire_info.len, sh[5:4]);
    chk("retire cycles", retire_info.cycles, sh[3:0]);
    if (sh[5:4] == 2'h3) begin
      chk("operand", retire_info.operand, op);
    end else if (sh[5:4] == 2'h2) begin
      chk("operand", retire_info.operand, op);
    end
  endtask : run_one

  // Run a sequence; mode_sel 3 draws classes and modes at random
  task automatic run_seq(input int count, input int mode_sel);
    cit_pkg::cit_class_t cur;
    cit_pkg::cit_class_t nxt;
    int m;
    cur = (mode_sel == 3) ? cit_pkg::cit_class_t'($urandom_range(25, 0))
                          : cit_pkg::CIT_ARITH_REG;
    issue_class = cur;
    issue_valid = 1'h1;
    #1;
    for (int k = 0; k < count; k++) begin
      nxt = (mode_sel == 3) ? cit_pkg::cit_class_t'($urandom_range(25, 0))
                            : cit_pkg::cit_class_t'((k + 1) % 26);
      m = (mode_sel == 3) ? int'($urandom_range(2, 0)) : mode_sel;
      if (k == count - 1) begin
        m = 0;
      end
      run_one(cur, m, nxt);
      if (m == 0) begin
        @(negedge ref_clk);
        #1;
        chk("busy idle", busy, 1'h0);
        chk("retire idle", retire_valid, 1'h0);
        if (k < count - 1) begin
          issue_class = nxt;
          issue_valid = 1'h1;
          #1;
        end
      end
      cur = nxt;
    end
  endtask : run_seq

  // Verdict and end of run
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // Cycle ceiling against hangs
  always @(posedge ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      bad_count++;
      $display("[ERR] timeout expected finish seen hang");
      complete_run();
    end
  end

  // ========================================================================
  // Main sequence
  // ========================================================================
  initial begin
    srst = 1'h1;
    issue_valid = 1'h0;
    issue_class = cit_pkg::CIT_ARITH_REG;
    code_data = 8'h00;
    void'($urandom(82796));
    repeat (5) @(negedge ref_clk);
    chk_reset();
    srst = 1'h0;
    run_seq(26, 0);
    $display("Test isolated classes done");
    run_seq(26, 1);
    $display("Test back to back done");
    run_seq(26, 2);
    $display("Test early offer done");
    run_seq(300, 3);
    $display("Test random mix done");
    // Reset in the middle of a divide
    @(negedge ref_clk);
    issue_class = cit_pkg::CIT_DIVIDE;
    issue_valid = 1'h1;
    repeat (3) @(negedge ref_clk);
    srst = 1'h1;
    issue_valid = 1'h0;
    @(negedge ref_clk);
    #1;
    chk_reset();
    srst = 1'h0;
    run_seq(4, 0);
    $display("Test mid reset done");
    complete_run();
  end
endmodule : tb_cpu_instruction_timing
